// ==== rtl/hps_pkg.sv ====
// Shared constants and types of the host port select and pin control block.
package hps_pkg;

  // ==========================================================================
  // Clock and reset timing
  localparam int CORE_CLK_HZ = 25_000_000;
  localparam int RESET_MIN_NS = 40;
  // Least reset pulse in core clock cycles, rounded up, at least one.
  localparam int RESET_MIN_CYC_RAW =
    (RESET_MIN_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int RESET_MIN_CYC = (RESET_MIN_CYC_RAW < 1) ? 1 :
    RESET_MIN_CYC_RAW;
  // Core cycles after reset release before the strap is taken.
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // ==========================================================================
  // Register bit positions
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_RTS_BIT = 1;
  localparam int EFR_AUTO_RTS_BIT = 6;
  localparam int EFR_AUTO_CTS_BIT = 7;
  localparam int MSR_CTS_BIT = 4;
  localparam int MSR_DSR_BIT = 5;
  localparam int MSR_RI_BIT = 6;
  localparam int MSR_CD_BIT = 7;

  // ==========================================================================
  // General-purpose pins
  localparam int GPIO_W = 8;
  localparam int GPIO_PLAIN = 4;
  localparam int GPIO_DSR = 4;
  localparam int GPIO_DTR = 5;
  localparam int GPIO_CD = 6;
  localparam int GPIO_RI = 7;

  // ==========================================================================
  // Serial host framing
  localparam int BYTE_W = 8;
  localparam logic [3:0] BIT_CNT_LAST = 4'h7;
  localparam logic [3:0] BIT_CNT_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_ONE = 4'h1;

  typedef enum logic {
    HPS_MODE_SPI = 1'b0,
    HPS_MODE_I2C = 1'b1
  } hps_mode_t;

  typedef enum logic [1:0] {
    HPS_I2C_IDLE = 2'b00,
    HPS_I2C_ADDR = 2'b01,
    HPS_I2C_ACK = 2'b10,
    HPS_I2C_SKIP = 2'b11
  } hps_i2c_state_t;

endpackage : hps_pkg

// ==== rtl/hps_top.sv ====
// Host port select, shared pin steering and modem pin control.
//
// Overview of operation
// - A high interface-select strap gives an I2C slave port, low gives SPI.
// - In SPI mode the first shared pin is an active-low chip select.
// - In I2C mode the two shared pins are the low slave address bits.
// - In SPI mode the second shared pin carries host data into the device.
// - The SPI data output is driven only in SPI mode and floats otherwise.
// - In I2C mode the data line is open-drain; in SPI mode it is never driven.
// - The active-low open-drain interrupt pulls low only for enabled sources.
// - With auto request-to-send off, a one in modem control bit 1 drives request-to-send low.
// - After reset request-to-send stays high until the strap is taken.
// - Request-to-send follows receive room only with auto request-to-send.
// - Pins 0 to 3 are plain I/O; pins 4 to 7 are I/O or modem signals.
// - Clear-to-send gates transmit only with auto clear-to-send on.
// - Reset clears outputs but sets request-to-send high, takes the strap after release, idles transmit, ignores receive.
`timescale 1ns/1ps
`default_nettype none

module hps_top #(
  parameter logic [6:0] I2C_BASE_ADDR = 7'h40
) (
  // Clocks and reset
  input wire logic core_clk_i,
  input wire logic link_clk_i,
  input wire logic rst_i,
  // Strap and shared host pins
  input wire logic host_sel_i,
  input wire logic chip_select_or_addr_bit0_i,
  input wire logic serial_in_or_addr_bit1_i,
  output logic spi_so_o,
  output logic spi_so_oe_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Host side results
  output logic spi_byte_valid_o,
  output logic [hps_pkg::BYTE_W-1:0] spi_byte_o,
  output logic i2c_match_o,
  output logic i2c_read_o,
  // Interrupt
  input wire logic [7:0] interrupt_enable_reg_i,
  input wire logic [7:0] irq_pending_i,
  output logic irq_n_o,
  output logic irq_n_oe_o,
  // Flow control and modem
  input wire logic [7:0] modem_control_reg_i,
  input wire logic [7:0] enhanced_feature_reg_i,
  input wire logic rx_room_i,
  input wire logic cts_n_i,
  output logic rts_n_o,
  output logic tx_allowed_o,
  output logic [7:0] modem_status_reg_o,
  output logic uart_run_o,
  // General-purpose pins
  input wire logic [hps_pkg::GPIO_W-1:0] gpio_dir_i,
  input wire logic [hps_pkg::GPIO_W-1:0] gpio_out_i,
  input wire logic [3:0] modem_sel_i,
  input wire logic [hps_pkg::GPIO_W-1:0] gpio_i,
  output logic [hps_pkg::GPIO_W-1:0] gpio_o,
  output logic [hps_pkg::GPIO_W-1:0] gpio_oe_o,
  output logic [hps_pkg::GPIO_W-1:0] gpio_in_o,
  output logic input_change_o
);

  // ==========================================================================
  // Pin synchronisers
  localparam int SYN_W = hps_pkg::GPIO_W + 6;
  logic [SYN_W-1:0] syn_a;
  logic [SYN_W-1:0] syn_b;
  logic [hps_pkg::GPIO_W-1:0] gpio_s;
  logic host_sel_s;
  logic cs_s;
  logic si_s;
  logic scl_s;
  logic sda_s;
  logic cts_n_s;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      syn_a <= '0;
      syn_b <= '0;
    end else begin
      syn_a <= {gpio_i, host_sel_i, chip_select_or_addr_bit0_i,
                serial_in_or_addr_bit1_i, scl_i, sda_i, cts_n_i};
      syn_b <= syn_a;
    end
  end

  assign {gpio_s, host_sel_s, cs_s, si_s, scl_s, sda_s, cts_n_s} = syn_b;

  // ==========================================================================
  // Strap capture
  // The synchronisers need two edges to fill, so the strap waits for them.
  logic [1:0] strap_wait;
  logic strap_taken;
  hps_pkg::hps_mode_t mode;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_wait <= 2'h0;
      strap_taken <= 1'b0;
      mode <= hps_pkg::HPS_MODE_SPI;
    end else if (!strap_taken) begin
      if (strap_wait == hps_pkg::STRAP_WAIT) begin
        strap_taken <= 1'b1;
        mode <= hps_pkg::hps_mode_t'(host_sel_s);
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  logic spi_on;
  logic i2c_on;
  assign spi_on = strap_taken && (mode == hps_pkg::HPS_MODE_SPI);
  assign i2c_on = strap_taken && (mode == hps_pkg::HPS_MODE_I2C);

  // ==========================================================================
  // SPI link domain
  // The host clock stops between frames, so chip select clears the bit
  // count directly; only the mode history, toggle and held byte survive a frame.
  logic link_rst;
  logic [1:0] spi_mode_l;
  logic [3:0] spi_cnt;
  logic [hps_pkg::BYTE_W-1:0] spi_sh;
  logic [hps_pkg::BYTE_W-1:0] spi_hold;
  logic spi_tgl;

  assign link_rst = rst_i || chip_select_or_addr_bit0_i;

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      spi_mode_l <= 2'b00;
    end else begin
      spi_mode_l <= {spi_mode_l[0], spi_on};
    end
  end

  always_ff @(posedge link_clk_i or posedge link_rst) begin
    if (link_rst) begin
      spi_cnt <= hps_pkg::BIT_CNT_ZERO;
      spi_sh <= '0;
    end else if (spi_mode_l[1]) begin
      spi_sh <= {spi_sh[hps_pkg::BYTE_W-2:0], serial_in_or_addr_bit1_i};
      spi_cnt <= (spi_cnt == hps_pkg::BIT_CNT_LAST) ? hps_pkg::BIT_CNT_ZERO :
                 spi_cnt + hps_pkg::BIT_CNT_ONE;
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      spi_hold <= '0;
      spi_tgl <= 1'b0;
    end else if (spi_mode_l[1] && !chip_select_or_addr_bit0_i &&
                 spi_cnt == hps_pkg::BIT_CNT_LAST) begin
      spi_hold <= {spi_sh[hps_pkg::BYTE_W-2:0], serial_in_or_addr_bit1_i};
      spi_tgl <= ~spi_tgl;
    end
  end

  // Mode 0: the output changes on the falling edge; it echoes the last bit.
  always_ff @(negedge link_clk_i or posedge link_rst) begin
    if (link_rst) begin
      spi_so_o <= 1'b0;
    end else begin
      spi_so_o <= spi_sh[0];
    end
  end

  // ==========================================================================
  // SPI byte hand-over to the core domain
  logic [2:0] tgl_sync;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgl_sync <= 3'h0;
      spi_byte_valid_o <= 1'b0;
      spi_byte_o <= '0;
      spi_so_oe_o <= 1'b0;
    end else begin
      tgl_sync <= {tgl_sync[1:0], spi_tgl};
      spi_byte_valid_o <= tgl_sync[2] ^ tgl_sync[1];
      if (tgl_sync[2] ^ tgl_sync[1]) begin
        spi_byte_o <= spi_hold;
      end
      spi_so_oe_o <= spi_on && !cs_s;
    end
  end

  // ==========================================================================
  // I2C address phase, oversampled on the core clock
  hps_pkg::hps_i2c_state_t i2c_state;
  logic scl_p;
  logic sda_p;
  logic [3:0] i2c_cnt;
  logic [hps_pkg::BYTE_W-1:0] i2c_sh;
  logic i2c_start;
  logic i2c_stop;
  logic addr_hit;

  assign i2c_start = scl_s && scl_p && sda_p && !sda_s;
  assign i2c_stop = scl_s && scl_p && !sda_p && sda_s;
  assign addr_hit = (i2c_sh[7:1] == {I2C_BASE_ADDR[6:2], si_s, cs_s});

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      i2c_state <= hps_pkg::HPS_I2C_IDLE;
      i2c_cnt <= hps_pkg::BIT_CNT_ZERO;
      i2c_sh <= '0;
      i2c_match_o <= 1'b0;
      i2c_read_o <= 1'b0;
    end else begin
      i2c_match_o <= 1'b0;
      if (!i2c_on || i2c_stop) begin
        i2c_state <= hps_pkg::HPS_I2C_IDLE;
      end else if (i2c_start) begin
        i2c_state <= hps_pkg::HPS_I2C_ADDR;
        i2c_cnt <= hps_pkg::BIT_CNT_ZERO;
      end else begin
        unique case (i2c_state)
          hps_pkg::HPS_I2C_IDLE: begin
          end
          hps_pkg::HPS_I2C_ADDR: begin
            if (scl_s && !scl_p) begin
              i2c_sh <= {i2c_sh[hps_pkg::BYTE_W-2:0], sda_s};
              i2c_cnt <= i2c_cnt + hps_pkg::BIT_CNT_ONE;
            end else if (!scl_s && scl_p &&
                         i2c_cnt == hps_pkg::BIT_CNT_BYTE) begin
              i2c_state <= addr_hit ? hps_pkg::HPS_I2C_ACK :
                           hps_pkg::HPS_I2C_SKIP;
              i2c_match_o <= addr_hit;
              i2c_read_o <= addr_hit ? i2c_sh[0] : i2c_read_o;
            end
          end
          hps_pkg::HPS_I2C_ACK: begin
            if (!scl_s && scl_p) begin
              i2c_state <= hps_pkg::HPS_I2C_SKIP;
            end
          end
          hps_pkg::HPS_I2C_SKIP: begin
          end
        endcase
      end
    end
  end

  // Open-drain: the driven level is always low.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_o <= i2c_on && (i2c_state == hps_pkg::HPS_I2C_ACK);
    end
  end

  // ==========================================================================
  // Interrupt, flow control and modem status
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_n_o <= 1'b0;
      irq_n_oe_o <= 1'b0;
      rts_n_o <= 1'b1;
      tx_allowed_o <= 1'b0;
      uart_run_o <= 1'b0;
    end else begin
      irq_n_o <= 1'b0;
      irq_n_oe_o <= |(irq_pending_i & interrupt_enable_reg_i);
      uart_run_o <= strap_taken;
      if (!strap_taken) begin
        rts_n_o <= 1'b1;
      end else if (enhanced_feature_reg_i[hps_pkg::EFR_AUTO_RTS_BIT]) begin
        rts_n_o <= !rx_room_i;
      end else begin
        rts_n_o <= !modem_control_reg_i[hps_pkg::MCR_RTS_BIT];
      end
      // Clear-to-send only holds off the transmitter under auto mode.
      tx_allowed_o <= strap_taken &&
        (!enhanced_feature_reg_i[hps_pkg::EFR_AUTO_CTS_BIT] || !cts_n_s);
    end
  end

  logic [3:0] modem_now;
  logic [3:0] modem_prev;
  logic [hps_pkg::GPIO_W-1:0] gpio_prev;

  // Order matches the status high nibble: carrier, ring, set-ready, clear.
  assign modem_now = {modem_sel_i[2] && !gpio_s[hps_pkg::GPIO_CD],
                      modem_sel_i[3] && !gpio_s[hps_pkg::GPIO_RI],
                      modem_sel_i[0] && !gpio_s[hps_pkg::GPIO_DSR],
                      !cts_n_s};

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      modem_prev <= 4'h0;
      gpio_prev <= '0;
      modem_status_reg_o <= 8'h00;
      gpio_in_o <= '0;
      input_change_o <= 1'b0;
    end else begin
      modem_prev <= modem_now;
      gpio_prev <= gpio_s;
      gpio_in_o <= gpio_s;
      input_change_o <= strap_taken && |(gpio_s ^ gpio_prev);
      modem_status_reg_o[hps_pkg::MSR_CTS_BIT] <= modem_now[0];
      modem_status_reg_o[hps_pkg::MSR_DSR_BIT] <= modem_now[1];
      modem_status_reg_o[hps_pkg::MSR_RI_BIT] <= modem_now[2];
      modem_status_reg_o[hps_pkg::MSR_CD_BIT] <= modem_now[3];
      // Low nibble flags a change of the matching high bit for one cycle.
      modem_status_reg_o[3:0] <= modem_now ^ modem_prev;
    end
  end

  // ==========================================================================
  // General-purpose pin steering
  genvar gi;
  generate
    for (gi = 0; gi < hps_pkg::GPIO_W; gi++) begin : g_pin
      logic as_modem;
      if (gi < hps_pkg::GPIO_PLAIN) begin : g_plain
        assign as_modem = 1'b0;
      end else begin : g_shared
        assign as_modem = modem_sel_i[gi - hps_pkg::GPIO_PLAIN];
      end
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          gpio_o[gi] <= 1'b0;
          gpio_oe_o[gi] <= 1'b0;
        end else if (as_modem) begin
          // Terminal-ready is the only modem output among the shared pins.
          gpio_oe_o[gi] <= (gi == hps_pkg::GPIO_DTR);
          gpio_o[gi] <= !modem_control_reg_i[hps_pkg::MCR_DTR_BIT];
        end else begin
          gpio_oe_o[gi] <= gpio_dir_i[gi];
          gpio_o[gi] <= gpio_out_i[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Checks
  sequence s_cts_held;
    (enhanced_feature_reg_i[hps_pkg::EFR_AUTO_CTS_BIT] && cts_n_i)[*3]
    ##1 enhanced_feature_reg_i[hps_pkg::EFR_AUTO_CTS_BIT];
  endsequence

  sequence s_cs_high;
    chip_select_or_addr_bit0_i[*3];
  endsequence

  a_mode_latch: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(strap_taken) |-> (mode == hps_pkg::hps_mode_t'($past(host_sel_s))))
    else $error("host mode differs from strap");

  a_cs_release: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    s_cs_high |=> !spi_so_oe_o)
    else $error("serial output driven without chip select");

  a_so_i2c_float: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    i2c_on |=> !spi_so_oe_o)
    else $error("serial output driven in I2C mode");

  a_sda_spi_float: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (sda_oe_o |-> !sda_o) and (spi_on |=> !sda_oe_o))
    else $error("data line driven high or in SPI mode");

  a_i2c_ack_drive: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(i2c_match_o) |=> sda_oe_o)
    else $error("address match not acknowledged");

  a_irq_mask: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    ((irq_pending_i & interrupt_enable_reg_i) == 8'h00) |=> !irq_n_oe_o)
    else $error("interrupt driven for masked source");

  a_rts_manual: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    strap_taken && !enhanced_feature_reg_i[hps_pkg::EFR_AUTO_RTS_BIT] &&
    modem_control_reg_i[hps_pkg::MCR_RTS_BIT] |=> !rts_n_o)
    else $error("request-to-send not asserted");

  a_rts_reset: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !strap_taken |=> rts_n_o)
    else $error("request-to-send low after reset");

  a_rts_auto: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    strap_taken && enhanced_feature_reg_i[hps_pkg::EFR_AUTO_RTS_BIT] &&
    !rx_room_i |=> rts_n_o)
    else $error("request-to-send low with receive full");

  a_dtr_drive: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    modem_sel_i[1] |=> gpio_oe_o[hps_pkg::GPIO_DTR] &&
      (gpio_o[hps_pkg::GPIO_DTR] ==
       !$past(modem_control_reg_i[hps_pkg::MCR_DTR_BIT])))
    else $error("terminal-ready pin not driven");

  a_cts_gate: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    s_cts_held |=> !tx_allowed_o)
    else $error("transmit allowed with clear-to-send off");

  a_run_hold: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !strap_taken |=> !uart_run_o && !tx_allowed_o)
    else $error("UART running before strap taken");

  a_strap_hold: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    strap_taken && $past(strap_taken) |-> $stable(mode))
    else $error("host mode changed during operation");

endmodule : hps_top

`default_nettype wire

// ==== test/hps_host_model.sv ====
// Behavioural host controller acting as SPI or I2C master.
`timescale 1ns/1ps
`default_nettype none

module hps_host_model (
  // Resolved data line
  input wire logic sda_i,
  // Host pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  output logic sda_pull_o
);
  localparam int HALF_SPI = 40;
  localparam int HALF_I2C = 400;

  // The link clock starts low, with the chip deselected.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    sda_pull_o = 1'b0;
  end

  // ==========================================================================
  // SPI master, mode 0
  // Two clock pulses with the chip deselected let the mode reach the link.
  task automatic prime;
    repeat (2) begin
      #HALF_SPI sclk_o = 1'b1;
      #HALF_SPI sclk_o = 1'b0;
    end
  endtask : prime

  // Sends the lowest n bits of w, most significant first, in one frame.
  task automatic spi_bits(input logic [31:0] w, input int n);
    cs_n_o = 1'b0;
    #7;
    for (int i = n - 1; i >= 0; i--) begin
      si_o = w[i];
      #HALF_SPI sclk_o = 1'b1;
      #HALF_SPI sclk_o = 1'b0;
    end
    #20 cs_n_o = 1'b1;
    // A released data line must not keep showing the last bit.
    si_o = ~si_o;
    // The deselect gap lets the next frame see chip select high.
    #HALF_SPI;
  endtask : spi_bits

  // ==========================================================================
  // I2C master
  task automatic set_addr_pins(input logic a0, input logic a1);
    cs_n_o = a0;
    si_o = a1;
  endtask : set_addr_pins

  // START, one address byte, sample of the acknowledge, STOP.
  task automatic i2c_addr(input logic [7:0] b, output logic ack);
    sclk_o = 1'b1;
    #HALF_I2C sda_pull_o = 1'b1;
    #HALF_I2C sclk_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #(HALF_I2C / 2) sda_pull_o = ~b[i];
      #(HALF_I2C / 2) sclk_o = 1'b1;
      #HALF_I2C sclk_o = 1'b0;
    end
    #(HALF_I2C / 2) sda_pull_o = 1'b0;
    #(HALF_I2C / 2) sclk_o = 1'b1;
    #(HALF_I2C / 2) ack = sda_i;
    #(HALF_I2C / 2) sclk_o = 1'b0;
    #(HALF_I2C / 2) sda_pull_o = 1'b1;
    #(HALF_I2C / 2) sclk_o = 1'b1;
    #HALF_I2C sda_pull_o = 1'b0;
    #HALF_I2C;
  endtask : i2c_addr
endmodule : hps_host_model

`default_nettype wire

// ==== test/tb_hps_top.sv ====
// Self-checking testbench of the host port select and pin control block.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_hps_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic host_sel = 1'b0;
  logic cts_n = 1'b1;
  logic rx_room = 1'b0;
  logic [7:0] interrupt_enable_reg = 8'h00, pend = 8'h00, modem_control_reg = 8'h00, enhanced_feature_reg = 8'h00;
  logic [7:0] dir = 8'h00, gout = 8'h00, gin = 8'hff;
  logic [3:0] msel = 4'h0;
  wire logic sclk, cs_n, si, pull, sda;
  logic so, so_oe, sda_o, sda_oe, bv, i2m, i2r, irq_n, irq_oe, rts_n, txa;
  logic run, chg;
  logic [7:0] sbyte, modem_status_reg, g_o, g_oe, g_in, exp_oe, exp_o, gin_old;
  logic [8:0] exp_q[$];
  logic [8:0] got, want;
  logic ack, spi_prev;
  logic [31:0] w;
  int error_cnt = 0;
  int checks = 0;
  int spi_bit_n = 0;

  always #20 clk = ~clk;
  // Open-drain data line with pull-up; grounded on the board in SPI mode.
  assign sda = !(!host_sel || pull || sda_oe);

  hps_top i_hps_top (.core_clk_i(clk), .link_clk_i(sclk), .rst_i(rst),
    .host_sel_i(host_sel), .chip_select_or_addr_bit0_i(cs_n),
    .serial_in_or_addr_bit1_i(si), .spi_so_o(so), .spi_so_oe_o(so_oe),
    .scl_i(sclk), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .spi_byte_valid_o(bv), .spi_byte_o(sbyte), .i2c_match_o(i2m),
    .i2c_read_o(i2r), .interrupt_enable_reg_i(interrupt_enable_reg), .irq_pending_i(pend),
    .irq_n_o(irq_n), .irq_n_oe_o(irq_oe), .modem_control_reg_i(modem_control_reg),
    .enhanced_feature_reg_i(enhanced_feature_reg), .rx_room_i(rx_room), .cts_n_i(cts_n),
    .rts_n_o(rts_n), .tx_allowed_o(txa), .modem_status_reg_o(modem_status_reg),
    .uart_run_o(run), .gpio_dir_i(dir), .gpio_out_i(gout),
    .modem_sel_i(msel), .gpio_i(gin), .gpio_o(g_o), .gpio_oe_o(g_oe),
    .gpio_in_o(g_in), .input_change_o(chg));

  hps_host_model i_hps_host_model (.sda_i(sda), .sclk_o(sclk),
    .cs_n_o(cs_n), .si_o(si), .sda_pull_o(pull));

  // ==========================================================================
  // Closing and helpers
  task automatic results;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic do_reset(input logic sel);
    rst = 1'b1;
    host_sel = sel;
    cyc(8);
    `CHK(rts_n, 1'b1)
    `CHK(run, 1'b0)
    rst = 1'b0;
    cyc(6);
  endtask : do_reset

  // ==========================================================================
  // Result monitor: each received unit retires the oldest expectation.
  always begin
    @(posedge clk);
    #1;
    if (bv === 1'b1 || i2m === 1'b1) begin
      got = (bv === 1'b1) ? {1'b0, sbyte} : {1'b1, 7'h00, i2r};
      want = (exp_q.size() > 0) ? exp_q.pop_front() : 9'bx;
      `CHK(got, want)
    end
  end

  // Link monitor: the serial output echoes the bit taken one clock earlier.
  always @(posedge sclk or posedge cs_n) begin
    if (cs_n === 1'b1 || host_sel === 1'b1) begin
      spi_bit_n = 0;
    end else begin
      if (spi_bit_n > 0) begin
        `CHK(so, spi_prev)
        `CHK(so_oe, 1'b1)
      end
      spi_prev = si;
      spi_bit_n++;
    end
  end

  initial begin
    #400_000;
    error_cnt++;
    results();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(26));
    @(negedge clk);
    do_reset(1'b0);
    repeat (8) begin
      interrupt_enable_reg = 8'($urandom);
      pend = 8'($urandom);
      cyc(2);
      `CHK(irq_oe, |(interrupt_enable_reg & pend))
      `CHK(irq_n, 1'b0)
    end
    for (int i = 0; i < 8; i++) begin
      {modem_control_reg[1], enhanced_feature_reg[6], rx_room} = i[2:0];
      cyc(2);
      `CHK(rts_n, enhanced_feature_reg[6] ? !rx_room : !modem_control_reg[1])
    end
    enhanced_feature_reg = 8'h00;
    for (int i = 0; i < 4; i++) begin
      {enhanced_feature_reg[7], cts_n} = i[1:0];
      cyc(5);
      `CHK(txa, !enhanced_feature_reg[7] || !cts_n)
      `CHK(modem_status_reg[4], !cts_n)
    end
    msel = 4'h3;
    modem_control_reg = 8'h00;
    repeat (4) begin
      dir = 8'($urandom);
      gout = 8'($urandom);
      gin_old = gin;
      gin = 8'($urandom);
      cyc(3);
      `CHK(chg, gin != gin_old)
      `CHK(modem_status_reg[3:0], {2'b00, gin[4] ^ gin_old[4], 1'b0})
      cyc(2);
      `CHK(chg, 1'b0)
      exp_oe = (dir & 8'hcf) | 8'h20;
      exp_o = gout | 8'h20;
      `CHK(g_oe, exp_oe)
      `CHK(g_o & exp_oe, exp_o & exp_oe)
      `CHK(g_in, gin)
      `CHK(modem_status_reg[5], !gin[4])
    end
    i_hps_host_model.prime();
    w = $urandom;
    for (int i = 3; i >= 0; i--) exp_q.push_back({1'b0, w[i*8 +: 8]});
    i_hps_host_model.spi_bits(w, 32);
    cyc(4);
    // A byte cut short by deselection is dropped.
    i_hps_host_model.spi_bits({29'h0, w[2:0]}, 3);
    exp_q.push_back({1'b0, w[7:0]});
    i_hps_host_model.spi_bits({24'h0, w[7:0]}, 8);
    cyc(10);
    `CHK(exp_q.size(), 0)
    i_hps_host_model.set_addr_pins(1'b0, 1'b1);
    do_reset(1'b1);
    `CHK(so_oe, 1'b0)
    `CHK(run, 1'b1)
    exp_q.push_back({1'b1, 8'h01});
    i_hps_host_model.i2c_addr({7'h42, 1'b1}, ack);
    `CHK(ack, 1'b0)
    i_hps_host_model.i2c_addr({7'h40, 1'b0}, ack);
    `CHK(ack, 1'b1)
    `CHK(sda_o, 1'b0)
    i_hps_host_model.spi_bits(32'h000000a5, 8);
    cyc(10);
    `CHK(exp_q.size(), 0)
    `CHK(so_oe, 1'b0)
    results();
  end
endmodule : tb_hps_top

`default_nettype wire
